/* File: src/atd_dispatch.sv */
// alarm and time-slot dispatcher: decides which handler program
// interrupts the running program, and when.
// assumes a sequencer that reports instruction boundaries, handler ends
// and nesting depth, and all inputs synchronous to mclk_i.
//
// Summary of operation
// (R1) alarm in run mode suspends execution and dispatches the alarm handler
// (R2) in stop mode every alarm is discarded, nothing recorded
// (R3) alarm without installed handler is dropped, program just continues
// (R4) alarms are detected on the rising edge of the request
// (R5) no alarm dispatch while an alarm handler runs
// (R6) alarm arriving during an alarm handler raises alarm error handler
// (R7) interval alarm cannot interrupt a running alarm handler either
// (R8) external alarms outrank all four time-slot channels
// (R9) interval versus alarm order selectable, interval first after reset
// (R10) preempt at instruction boundaries, built-in routines only at points
// (R11) mask op holds alarms pending until unmask op
// (R12) every accepted alarm is acknowledged by hardware
// (R13) process image refresh halts while an alarm handler runs
// (R14) start-up keeps alarms masked unless unmasked there
// (R15) alarm calls count toward the 32 level nesting limit
// (R16) four slot channels, highest served first when due together
// (R17) slot period is interval value times 10 ms
// (R18) slot request comes from the internal tick and interrupts cyclic
// (R19) after a slot handler ends the interrupted program resumes
// (R20) highest slot channel resets to interval 10, 100 ms
// (R21) interval zero disables a channel; second-highest off at reset
// (R22) all pending: interval alarm, then alarm, then slots
// (R23) slot handler preemptible by alarms, resumes after they end
// (R24) slot requests during a slot handler are dropped
// (R25) slot counters run on a common 10 ms tick and reload
// (R26) pending alarm is dispatched once unmasked and no alarm runs
// (R27) dispatch presents the handler index to the sequencer
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "atd_params.svh"

module atd_dispatch #(
  parameter int unsigned TICK_CYCLES =
    `ATD_SLOT_TICK_MS * 1000 * `ATD_CLK_MHZ
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // event sources
  input wire logic alarm_req_i,
  input wire logic interval_req_i,
  // sequencer status
  input wire logic run_i,
  input wire logic startup_i,
  input wire logic insn_boundary_i,
  input wire logic in_builtin_i,
  input wire logic builtin_point_i,
  input wire logic mask_alarms_op_i,
  input wire logic unmask_alarms_op_i,
  input wire logic handler_done_i,
  input wire logic [5:0] nest_level_i,
  // dispatch to sequencer
  output logic dispatch_o,
  output atd_pkg::atd_hidx_t handler_idx_o,
  output logic alarm_ack_o,
  output logic image_refresh_en_o
);
  import atd_pkg::*;

  atd_state_t s_r;
  atd_state_t s_nxt;

  // installed bit of a handler
  function automatic logic installed(input logic [6:0] inst,
                                     input atd_hidx_t h);
    installed = inst[h];
  endfunction

  // handler index for a slot channel
  function automatic atd_hidx_t slot_hidx(input logic [1:0] ch);
    case (ch)
      2'd0: slot_hidx = HX_SLOT0;
      2'd1: slot_hidx = HX_SLOT1;
      2'd2: slot_hidx = HX_SLOT2;
      default: slot_hidx = HX_SLOT3;
    endcase
  endfunction

  // alarm-class levels are the ones with the upper bit set
  function automatic logic in_alarm_level(input atd_level_t lv);
    in_alarm_level = lv[1];
  endfunction

  // a channel expires on the tick that finds its counter at one
  function automatic logic slot_expires(input logic tk,
                                        input logic [15:0] ival,
                                        input logic [15:0] cnt);
    slot_expires = tk && ival != 16'h0000 && cnt <= 16'h0001;
  endfunction

  logic alarm_rise;
  logic can_preempt;
  logic alarm_busy;
  logic nest_ok;
  logic tick;
  logic take_alarm_class;
  logic [1:0] slot_ch;
  logic slot_any;
  logic [3:0] due;

  always_comb begin
    s_nxt = s_r;
    s_nxt.disp = 1'b0;
    s_nxt.ack = 1'b0;
    s_nxt.alm_q = alarm_req_i;
    s_nxt.start_q = startup_i;
    take_alarm_class = 1'b0;

    // edge only: a line held high is one alarm, not many
    alarm_rise = alarm_req_i & ~s_r.alm_q; // [R4]
    can_preempt = insn_boundary_i &
                  (~in_builtin_i | builtin_point_i); // [R10]
    alarm_busy = in_alarm_level(s_r.lvl); // [R5] [R7]
    nest_ok = nest_level_i < `ATD_NEST_MAX; // [R15]

    // highest due slot channel wins; the last hit of the scan is highest
    slot_any = |s_r.slot_p;
    slot_ch = 2'd0;
    for (int i = 0; i < 4; i++) begin
      if (s_r.slot_p[i]) begin
        slot_ch = 2'(i); // [R16]
      end
    end

    // register writes; an interval write restarts its channel at once, except in a tick cycle of an enabled channel
    if (wr_i) begin
      case (addr_i)
        `ATD_OFS_CTRL: begin
          s_nxt.alarm_first = wdata_i[`ATD_CTRL_ALARM_FIRST]; // [R9]
          s_nxt.inst = wdata_i[`ATD_CTRL_INST_MSB:`ATD_CTRL_INST_LSB];
        end
        `ATD_OFS_STATUS: begin
          if (wdata_i[`ATD_ST_NEST_ERR]) begin
            s_nxt.nest_err = 1'b0;
          end
        end
        `ATD_OFS_SLOT0, `ATD_OFS_SLOT1,
        `ATD_OFS_SLOT2, `ATD_OFS_SLOT3: begin
          s_nxt.ival[addr_i[3:2]] = wdata_i[15:0]; // [R17]
          s_nxt.cnt[addr_i[3:2]] = wdata_i[15:0];
        end
        default: begin
        end
      endcase
    end

    // register reads, answer in the next cycle only
    s_nxt.rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        `ATD_OFS_CTRL: begin
          s_nxt.rdata[`ATD_CTRL_ALARM_FIRST] = s_r.alarm_first;
          s_nxt.rdata[`ATD_CTRL_INST_MSB:`ATD_CTRL_INST_LSB] = s_r.inst;
        end
        `ATD_OFS_STATUS: begin
          s_nxt.rdata[`ATD_ST_LEVEL_LSB +: 2] = s_r.lvl;
          s_nxt.rdata[`ATD_ST_MASK] = s_r.mask;
          s_nxt.rdata[`ATD_ST_ALARM_PEND] = s_r.alm_p;
          s_nxt.rdata[`ATD_ST_ERR_PEND] = s_r.err_p;
          s_nxt.rdata[`ATD_ST_IVAL_PEND] = s_r.ival_p;
          s_nxt.rdata[`ATD_ST_SLOT_PEND_LSB +: 4] = s_r.slot_p;
          s_nxt.rdata[`ATD_ST_NEST_ERR] = s_r.nest_err;
        end
        `ATD_OFS_SLOT0, `ATD_OFS_SLOT1,
        `ATD_OFS_SLOT2, `ATD_OFS_SLOT3: begin
          s_nxt.rdata[15:0] = s_r.ival[addr_i[3:2]];
        end
        default: begin
        end
      endcase
    end

    // mask handling; start-up entry masks until unmask op or start-up end
    if (startup_i & ~s_r.start_q) begin
      s_nxt.mask = 1'b1; // [R14]
    end else if (~startup_i & s_r.start_q) begin
      s_nxt.mask = 1'b0; // [R14]
    end
    // a mask op beats an unmask op in the same cycle
    if (mask_alarms_op_i) begin
      s_nxt.mask = 1'b1; // [R11]
    end else if (unmask_alarms_op_i) begin
      s_nxt.mask = 1'b0; // [R11]
    end

    // common 10 ms tick; slot counters reload on expiry
    tick = s_r.pre == `ATD_TICK_W'(TICK_CYCLES - 1);
    s_nxt.pre = tick ? '0 : s_r.pre + 22'h00_0001; // [R25]
    for (int i = 0; i < 4; i++) begin
      due[i] = slot_expires(tick, s_r.ival[i], s_r.cnt[i]); // [R21]
      if (due[i]) begin
        s_nxt.cnt[i] = s_r.ival[i]; // [R25]
      end else if (tick && s_r.ival[i] != 16'h0000) begin
        s_nxt.cnt[i] = s_r.cnt[i] - 16'h0001; // [R17]
      end
    end

    // dispatch decision; one per cycle keeps index and ack unambiguous
    if (!run_i) begin
      // stop mode forgets every pending event and the handler level
      // no request survives, so a later run starts with nothing queued
      s_nxt.alm_p = 1'b0; // [R2]
      s_nxt.err_p = 1'b0; // [R2]
      s_nxt.ival_p = 1'b0;
      s_nxt.slot_p = 4'h0;
      s_nxt.lvl = LV_CYCLIC;
    end else begin
      if (can_preempt && nest_ok && !alarm_busy) begin
        // alarm class: interval first unless alarm-first selected
        if (s_r.ival_p && (!s_r.alarm_first ||
            ((!s_r.alm_p && !s_r.err_p) || s_r.mask))) begin // [R9] [R22]
          s_nxt.ival_p = 1'b0;
          if (installed(s_r.inst, HX_INTERVAL)) begin
            s_nxt.disp = 1'b1;
            s_nxt.idx = HX_INTERVAL; // [R27]
            take_alarm_class = 1'b1;
          end
        end else if (s_r.err_p && !s_r.mask) begin // [R6]
          s_nxt.err_p = 1'b0;
          if (installed(s_r.inst, HX_ALARM_ERR)) begin
            s_nxt.disp = 1'b1;
            s_nxt.idx = HX_ALARM_ERR;
            take_alarm_class = 1'b1;
          end
        end else if (s_r.alm_p && !s_r.mask) begin // [R26] [R8]
          s_nxt.alm_p = 1'b0;
          s_nxt.ack = 1'b1; // [R12]
          if (installed(s_r.inst, HX_ALARM)) begin // [R3]
            s_nxt.disp = 1'b1; // [R1]
            s_nxt.idx = HX_ALARM;
            take_alarm_class = 1'b1;
          end
        end else if (slot_any && s_r.lvl == LV_CYCLIC) begin // [R18]
          s_nxt.slot_p[slot_ch] = 1'b0;
          if (installed(s_r.inst, slot_hidx(slot_ch))) begin
            s_nxt.disp = 1'b1;
            s_nxt.idx = slot_hidx(slot_ch); // [R16]
            s_nxt.lvl = LV_SLOT;
          end
        end
      end

      // an alarm handler may stack on top of a slot handler
      if (take_alarm_class) begin
        s_nxt.lvl = (s_r.lvl == LV_SLOT) ? LV_ALARM_SLOT : LV_ALARM; // [R23]
      end

      // end of the innermost handler
      if (handler_done_i && !take_alarm_class) begin
        case (s_r.lvl)
          LV_ALARM: s_nxt.lvl = LV_CYCLIC;
          LV_ALARM_SLOT: s_nxt.lvl = LV_SLOT; // [R23]
          LV_SLOT: s_nxt.lvl = LV_CYCLIC; // [R19]
          default: s_nxt.lvl = LV_CYCLIC;
        endcase
      end

      // new events are set after the clears so none is lost
      if (alarm_rise) begin
        if (alarm_busy || take_alarm_class) begin
          s_nxt.err_p = 1'b1; // [R6]
        end else begin
          s_nxt.alm_p = 1'b1; // [R11]
        end
      end
      if (interval_req_i) begin
        s_nxt.ival_p = 1'b1; // [R7]
      end
      // dropped, not queued: slot timing stays on the tick grid
      for (int i = 0; i < 4; i++) begin
        if (due[i] &&
            s_r.lvl != LV_SLOT && s_r.lvl != LV_ALARM_SLOT &&
            s_nxt.lvl != LV_SLOT) begin // [R24]
          s_nxt.slot_p[i] = 1'b1; // [R18]
        end
      end
    end

    // a blocked dispatch at the nesting limit is reported
    if (run_i && can_preempt && !nest_ok && !alarm_busy &&
        (s_r.ival_p || s_r.alm_p || s_r.err_p || slot_any)) begin
      s_nxt.nest_err = 1'b1; // [R15]
    end

    // alarm handlers freeze the image; only direct accesses move i/o
    s_nxt.img = !in_alarm_level(s_nxt.lvl); // [R13]
  end

  // the whole state is one register; install and slot interval reset values from the header
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_r.lvl <= LV_CYCLIC;
      s_r.mask <= 1'b0;
      s_r.alm_q <= 1'b0;
      s_r.start_q <= 1'b0;
      s_r.alm_p <= 1'b0;
      s_r.err_p <= 1'b0;
      s_r.ival_p <= 1'b0;
      s_r.slot_p <= 4'h0;
      s_r.alarm_first <= 1'b0; // [R9]
      s_r.inst <= `ATD_RST_INST;
      s_r.ival[0] <= `ATD_RST_SLOT0;
      s_r.ival[1] <= `ATD_RST_SLOT1;
      s_r.ival[2] <= `ATD_RST_SLOT2; // [R21]
      s_r.ival[3] <= `ATD_RST_SLOT3; // [R20]
      s_r.cnt[0] <= `ATD_RST_SLOT0;
      s_r.cnt[1] <= `ATD_RST_SLOT1;
      s_r.cnt[2] <= `ATD_RST_SLOT2;
      s_r.cnt[3] <= `ATD_RST_SLOT3;
      s_r.pre <= 22'h00_0000;
      s_r.nest_err <= 1'b0;
      s_r.rdata <= 32'h0000_0000;
      s_r.disp <= 1'b0;
      s_r.idx <= HX_ALARM;
      s_r.ack <= 1'b0;
      s_r.img <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // every output is a flip-flop of the state, no logic after it
  assign rdata_o = s_r.rdata;
  assign dispatch_o = s_r.disp;
  assign handler_idx_o = s_r.idx;
  assign alarm_ack_o = s_r.ack;
  assign image_refresh_en_o = s_r.img;

endmodule

/* File: shared/atd_params.svh */
// constants for the alarm and time-slot dispatcher
// assumes byte addresses on an 8-bit register port, 32-bit data
`ifndef ATD_PARAMS_SVH
`define ATD_PARAMS_SVH

// clock and timing
`define ATD_CLK_MHZ 200
`define ATD_SLOT_TICK_MS 10
`define ATD_TICK_W 22
`define ATD_NEST_MAX 6'd32

// register byte offsets
`define ATD_OFS_CTRL 8'h00
`define ATD_OFS_STATUS 8'h04
`define ATD_OFS_SLOT0 8'h10
`define ATD_OFS_SLOT1 8'h14
`define ATD_OFS_SLOT2 8'h18
`define ATD_OFS_SLOT3 8'h1C

// control register fields
`define ATD_CTRL_ALARM_FIRST 0
`define ATD_CTRL_INST_LSB 1
`define ATD_CTRL_INST_MSB 7

// status register fields
`define ATD_ST_LEVEL_LSB 0
`define ATD_ST_MASK 2
`define ATD_ST_ALARM_PEND 3
`define ATD_ST_ERR_PEND 4
`define ATD_ST_IVAL_PEND 5
`define ATD_ST_SLOT_PEND_LSB 6
`define ATD_ST_NEST_ERR 10

// reset values
`define ATD_RST_INST 7'h7F
`define ATD_RST_SLOT0 16'h0000
`define ATD_RST_SLOT1 16'h0000
`define ATD_RST_SLOT2 16'h0000
`define ATD_RST_SLOT3 16'h000A

`endif

/* File: shared/atd_pkg.sv */
// types for the alarm and time-slot dispatcher
// constants live in atd_params.svh
package atd_pkg;

  // which handler program is being entered
  typedef enum logic [2:0] {
    HX_ALARM     = 3'b000,
    HX_ALARM_ERR = 3'b001,
    HX_INTERVAL  = 3'b010,
    HX_SLOT0     = 3'b011,
    HX_SLOT1     = 3'b100,
    HX_SLOT2     = 3'b101,
    HX_SLOT3     = 3'b110
  } atd_hidx_t;

  // what is running right now
  typedef enum logic [1:0] {
    LV_CYCLIC     = 2'b00,
    LV_SLOT       = 2'b01,
    LV_ALARM      = 2'b10,
    LV_ALARM_SLOT = 2'b11
  } atd_level_t;

  typedef struct packed {
    atd_level_t lvl;
    logic mask;
    logic alm_q;
    logic start_q;
    logic alm_p;
    logic err_p;
    logic ival_p;
    logic [3:0] slot_p;
    logic alarm_first;
    logic [6:0] inst;
    logic [3:0][15:0] ival;
    logic [3:0][15:0] cnt;
    logic [21:0] pre;
    logic nest_err;
    logic [31:0] rdata;
    logic disp;
    atd_hidx_t idx;
    logic ack;
    logic img;
  } atd_state_t;

endpackage

/* File: test/atd_dispatch_monitor.sv */
// port assertions for the alarm and time-slot dispatcher
// assumes one clock domain, bound into every atd_dispatch
`timescale 1ns/1ps
module atd_dispatch_monitor (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // inputs
  input wire logic rd_i,
  input wire logic run_i,
  input wire logic insn_boundary_i,
  input wire logic in_builtin_i,
  input wire logic builtin_point_i,
  input wire logic mask_alarms_op_i,
  input wire logic unmask_alarms_op_i,
  input wire logic handler_done_i,
  input wire logic [5:0] nest_level_i,
  // outputs
  input wire logic [31:0] rdata_o,
  input wire logic dispatch_o,
  input wire atd_pkg::atd_hidx_t handler_idx_o,
  input wire logic alarm_ack_o,
  input wire logic image_refresh_en_o
);
  import atd_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  logic alm_d;
  assign alm_d = dispatch_o && handler_idx_o == HX_ALARM;
  property p_stop; !run_i |=> !dispatch_o; endproperty
  a_stop: assert property (p_stop) else $error("dispatch in stop");
  property p_take; dispatch_o |-> $past(run_i && insn_boundary_i &&
    (!in_builtin_i || builtin_point_i)); endproperty
  a_take: assert property (p_take) else $error("bad point");
  property p_nest; dispatch_o |-> $past(nest_level_i) < 6'h20; endproperty
  a_nest: assert property (p_nest) else $error("too deep");
  property p_ack; alm_d |-> alarm_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_img; alm_d |-> !image_refresh_en_o; endproperty
  a_img: assert property (p_img) else $error("image on");
  // a handler end may legally open the way, so it is left out here
  property p_block; !image_refresh_en_o && !dispatch_o && !handler_done_i
    |=> !dispatch_o; endproperty
  a_block: assert property (p_block) else $error("nested");
  property p_mask; mask_alarms_op_i ##1 !unmask_alarms_op_i[*3]
    |=> !alm_d; endproperty
  a_mask: assert property (p_mask) else $error("masked taken");
  property p_rd; !rd_i |=> rdata_o == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
  c_err: cover property (dispatch_o && handler_idx_o == HX_ALARM_ERR);
  c_ival: cover property (dispatch_o && handler_idx_o == HX_INTERVAL);
  c_slot: cover property (dispatch_o && handler_idx_o == HX_SLOT3);
endmodule

bind atd_dispatch atd_dispatch_monitor u_mon (.mclk_i(mclk_i),
  .rst_i(rst_i), .rd_i(rd_i), .run_i(run_i),
  .insn_boundary_i(insn_boundary_i), .in_builtin_i(in_builtin_i),
  .builtin_point_i(builtin_point_i),
  .mask_alarms_op_i(mask_alarms_op_i),
  .unmask_alarms_op_i(unmask_alarms_op_i),
  .handler_done_i(handler_done_i), .nest_level_i(nest_level_i),
  .rdata_o(rdata_o), .dispatch_o(dispatch_o),
  .handler_idx_o(handler_idx_o), .alarm_ack_o(alarm_ack_o),
  .image_refresh_en_o(image_refresh_en_o));

/* File: test/atd_alarm_src.sv */
// model of an alarm-capable peripheral on the backplane
// assumes fire_i is a one-cycle pulse synchronous to mclk_i
`timescale 1ns/1ps
module atd_alarm_src (
  // clock
  input wire logic mclk_i,
  // control
  input wire logic fire_i,
  input wire logic [3:0] hold_i,
  // alarm line
  output logic alarm_req_o
);
  logic [3:0] cnt_r = 4'h0;
  initial alarm_req_o = 1'b0;
  // line held a while; only the rise may count as a new alarm
  always @(posedge mclk_i) begin
    if (fire_i) begin
      cnt_r <= hold_i;
      alarm_req_o <= 1'b1;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else begin
      alarm_req_o <= 1'b0;
    end
  end
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the alarm and time-slot dispatcher
// assumes the slot tick shortened to 20 clocks
`timescale 1ns/1ps
module tb_top;
  import atd_pkg::*;
  localparam int TK = 20;
  logic mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, run_i = 1;
  logic startup_i = 0, insn_boundary_i = 1, in_builtin_i = 0;
  logic builtin_point_i = 0, mask_alarms_op_i = 0, unmask_alarms_op_i = 0;
  logic handler_done_i = 0, interval_req_i = 0, fire = 0, rnd_on = 1;
  logic alarm_req_i, dispatch_o, alarm_ack_o, image_refresh_en_o;
  logic [3:0] hold = 4'h1;
  logic [5:0] nest_level_i = 6'h00;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, r;
  atd_hidx_t handler_idx_o;
  int fail_count = 0, n_compared = 0, n_disp = 0, t_disp = 0, cyc_n = 0;
  int seed = 32'h8C8ACBB4, t1, q[$];
  atd_alarm_src src (.mclk_i(mclk_i), .fire_i(fire), .hold_i(hold),
    .alarm_req_o(alarm_req_i));
  atd_dispatch #(.TICK_CYCLES(TK)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .alarm_req_i(alarm_req_i),
    .interval_req_i(interval_req_i), .run_i(run_i), .startup_i(startup_i),
    .insn_boundary_i(insn_boundary_i), .in_builtin_i(in_builtin_i),
    .builtin_point_i(builtin_point_i), .mask_alarms_op_i(mask_alarms_op_i),
    .unmask_alarms_op_i(unmask_alarms_op_i),
    .handler_done_i(handler_done_i), .nest_level_i(nest_level_i),
    .dispatch_o(dispatch_o), .handler_idx_o(handler_idx_o),
    .alarm_ack_o(alarm_ack_o), .image_refresh_en_o(image_refresh_en_o));
  always #2.5 mclk_i = ~mclk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // random preemption points make dispatch latency vary while rnd_on is set
  always @(posedge mclk_i) begin
    cyc_n <= cyc_n + 1;
    r = $random(seed);
    insn_boundary_i <= !rnd_on || r[0] || r[3];
    in_builtin_i <= rnd_on && r[1];
    builtin_point_i <= r[2];
  end
  // reference order of handler entries lives in q
  always @(posedge mclk_i) if (!rst_i && dispatch_o === 1'b1) begin
    n_disp <= n_disp + 1;
    t_disp <= cyc_n;
    chk({29'h0, handler_idx_o}, q.size() ? q.pop_front() : 8);
    if (handler_idx_o == HX_ALARM) begin
      chk({30'h0, alarm_ack_o, image_refresh_en_o}, 32'h2);
    end
  end
  task cy(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i) wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i) wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i) rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i) rd_i <= 1'b0;
    @(negedge mclk_i) chk(rdata_o, e);
    @(posedge mclk_i);
  endtask
  task alm(input logic [3:0] h);
    @(posedge mclk_i) fire <= 1'b1;
    hold <= h;
    @(posedge mclk_i) fire <= 1'b0;
  endtask
  task wt;
    int k;
    k = n_disp;
    repeat (300) if (n_disp == k) @(posedge mclk_i);
  endtask
  task fin;
    @(posedge mclk_i) handler_done_i <= 1'b1;
    @(posedge mclk_i) handler_done_i <= 1'b0;
  endtask
  task serve;
    wt();
    fin();
  endtask
  task stop_test;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    cy(20);
    rst_i <= 1'b0;
    rd(8'h00, 32'hFE);
    rd(8'h1C, 32'hA);
    rd(8'h14, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h1C, 32'h0);
    q.push_back(0);
    alm(4'hA);
    serve();
    cy(20);
    q = '{0, 1};
    alm(4'h1);
    wt();
    cy(3);
    alm(4'h1);
    cy(4);
    fin();
    serve();
    run_i <= 1'b0;
    alm(4'h1);
    cy(6);
    run_i <= 1'b1;
    rd(8'h04, 32'h0);
    wr(8'h00, 32'hFC);
    alm(4'h1);
    cy(10);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'hFE);
    @(posedge mclk_i) mask_alarms_op_i <= 1'b1;
    @(posedge mclk_i) mask_alarms_op_i <= 1'b0;
    alm(4'h1);
    cy(6);
    rd(8'h04, 32'hC);
    q.push_back(0);
    @(posedge mclk_i) unmask_alarms_op_i <= 1'b1;
    @(posedge mclk_i) unmask_alarms_op_i <= 1'b0;
    serve();
    startup_i <= 1'b1;
    alm(4'h1);
    cy(6);
    q.push_back(0);
    startup_i <= 1'b0;
    serve();
    for (int c = 0; c < 2; c++) begin
      wr(8'h00, 32'hFE | c);
      nest_level_i <= 6'h20;
      alm(4'h1);
      @(posedge mclk_i) interval_req_i <= 1'b1;
      @(posedge mclk_i) interval_req_i <= 1'b0;
      cy(4);
      rd(8'h04, 32'h428);
      q = '{c ? 0 : 2, c ? 2 : 0};
      nest_level_i <= 6'h00;
      wr(8'h04, 32'h400);
      serve();
      serve();
    end
    wr(8'h00, 32'hFE);
    rd(8'h04, 32'h0);
    // fixed latency here so the spacing of entries is exact
    rnd_on <= 1'b0;
    wr(8'h14, 32'h3);
    q = '{4, 4};
    serve();
    t1 = t_disp;
    serve();
    chk(t_disp - t1, 3 * TK);
    wr(8'h14, 32'h0);
    rnd_on <= 1'b1;
    nest_level_i <= 6'h20;
    wr(8'h10, 32'h1);
    wr(8'h1C, 32'h1);
    cy(50);
    wr(8'h10, 32'h0);
    wr(8'h1C, 32'h0);
    q = '{6, 0, 3};
    nest_level_i <= 6'h00;
    wt();
    alm(4'h1);
    serve();
    fin();
    serve();
    cy(20);
    chk(q.size(), 0);
    stop_test();
  end
  initial begin
    #100us;
    fail_count++;
    stop_test();
  end
endmodule
